// [rtl/mfx_ext_addr.sv]
// extended address select and output register
`timescale 1ns/1ns
module mfx_ext_addr #(
   parameter int FIELD_W = 3
) (
   input  wire logic               pclk,        // system clock
   input  wire logic               presetn,     // async reset, low
   input  wire logic               cyc_start,   // memory cycle begins
   input  wire logic [2:0]         cyc_phase,   // one-hot phase
   input  wire logic               cyc_mri,     // and/tad/isz/dca
   input  wire logic               map_en,      // mapping enabled
   input  wire logic [FIELD_W-1:0] instr_field, // active code field
   input  wire logic [FIELD_W-1:0] data_field,  // active data field
   output logic      [FIELD_W-1:0] ext_addr,    // extended address
   output logic                    after_defer  // last cycle indirect
);

   // data field only for an operand fetched through a pointer
   wire is_exec  = cyc_phase == mfx_pkg::MFX_PH_EXEC;
   wire is_defer = cyc_phase == mfx_pkg::MFX_PH_DEFER;
   wire use_df   = is_exec && cyc_mri && after_defer;
   wire [FIELD_W-1:0] next_ext_addr =
      !map_en ? '0 : use_df ? data_field : instr_field;

   // address held for the whole memory cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_addr    <= '0;
         after_defer <= 1'b0;
      end else if (cyc_start) begin
         ext_addr    <= next_ext_addr;
         after_defer <= is_defer;
      end
   end

endmodule // mfx_ext_addr

// [rtl/mfx_field_ext.sv]
// memory field extension: field registers, commands and register port
//
// Behaviour
// - fetches and direct operands use the instruction field
// - indirect pointer words for the four operand ops come from code field
// - data field only in execute right after an indirect phase
// - auto-index read, increment, rewrite stay in the code field
// - change code field loads only the buffer; jumps copy it over
// - jumps never touch the data field
// - code field extends the 12-bit program counter at its top
// - after change code field, interrupts wait for the next jump
// - program counter wrap never increments the code field
// - interrupt entry saves fields, then clears code and data fields
// - saved counter write and first service fetch go to field zero
// - restore loads buffer and data field from the save field
// - interrupt saves the buffer, not the active code field
// - interrupts held off while buffer and code field differ
// - panel mode suppresses buffer transfer on jumps
// - load code field works even in panel mode
// - flag and save reads return save field; only one reads code field
// - read data field ORs it into bits 3 to 5
// - restore: buffer gets save bits 3-5, data field bits 0-2
// - load code field copies buffer and clears inhibit at once
// - change data field takes the N digit as field number
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module mfx_field_ext #(
   parameter int FIELD_W = 3,
   parameter int ACC_W   = 12
) (
   input  wire logic               pclk,        // system clock
   input  wire logic               presetn,     // async reset, low
   input  wire logic               psel,        // apb select
   input  wire logic               penable,     // apb access phase
   input  wire logic               pwrite,      // apb write
   input  wire logic [11:0]        paddr,       // apb byte address
   input  wire logic [31:0]        pwdata,      // apb write data
   output logic      [31:0]        prdata,      // apb read data
   output logic                    pready,      // apb ready
   output logic                    pslverr,     // apb error
   input  wire logic               cyc_start,   // memory cycle begins
   input  wire logic [2:0]         cyc_phase,   // one-hot phase
   input  wire logic               cyc_mri,     // and/tad/isz/dca
   input  wire logic               iot_stb,     // i/o instruction pulse
   input  wire logic [ACC_W-1:0]   iot_code,    // instruction word
   input  wire logic [ACC_W-1:0]   acc_in,      // working register in
   output logic      [ACC_W-1:0]   acc_out,     // working register out
   output logic                    acc_load,    // acc_out valid pulse
   input  wire logic               jump_exec,   // jump/jump_subroutine
   input  wire logic               panel_mode,  // panel memory running
   input  wire logic               int_ack,     // interrupt entered
   output logic                    int_inhibit, // interrupts blocked
   output logic      [FIELD_W-1:0] ext_addr     // extended address lines
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (FIELD_W != mfx_pkg::FW || ACC_W != mfx_pkg::AW) begin : g_chk
      $error("field and working register widths are fixed");
   end

   // ****************************************************************
   // field state
   // ****************************************************************
   logic [FIELD_W-1:0]   instr_field;
   logic [FIELD_W-1:0]   instruction_field_buffer;
   logic [FIELD_W-1:0]   data_field;
   logic [2*FIELD_W-1:0] save_field;
   logic                 inhibit;
   logic [31:0]          ctrl;
   logic                 after_defer;

   // read result OR-ed into the working register
   function automatic logic [ACC_W-1:0] or_mid(
      input logic [FIELD_W-1:0] f
   );
      or_mid = {{(ACC_W-2*FIELD_W){1'b0}}, f, {FIELD_W{1'b0}}};
   endfunction

   // ****************************************************************
   // command decode
   // ****************************************************************
   wire [FIELD_W-1:0] n_dig = iot_code[5:3];
   wire [2:0]         sub   = iot_code[2:0];
   wire grp     = iot_stb && iot_code[11:6] == mfx_pkg::IOT_GRP;
   wire cmd_cdf = grp && (sub == mfx_pkg::SUB_CDF ||
                          sub == mfx_pkg::SUB_CDIF);
   wire cmd_cif = grp && (sub == mfx_pkg::SUB_CIF ||
                          sub == mfx_pkg::SUB_CDIF);
   wire misc    = grp && sub == mfx_pkg::SUB_MISC;
   wire cmd_rdf = misc && n_dig == mfx_pkg::N_RDF;
   wire cmd_rif = misc && n_dig == mfx_pkg::N_RIF;
   wire cmd_rsf = misc && n_dig == mfx_pkg::N_RSF;
   wire cmd_rmf = misc && n_dig == mfx_pkg::N_RMF;
   wire cmd_lif = misc && n_dig == mfx_pkg::N_LIF;
   wire cmd_gtf = iot_stb && iot_code == mfx_pkg::GTF_CODE;
   wire cmd_rtf = iot_stb && iot_code == mfx_pkg::RTF_CODE;
   wire cmd_rd  = cmd_rdf || cmd_rif || cmd_rsf || cmd_gtf;
   wire map_en  = ctrl[mfx_pkg::CTRL_MAP];

   // ****************************************************************
   // next field values
   // ****************************************************************
   // panel suppresses jump copy
   wire do_xfer = cmd_lif || (jump_exec && !panel_mode);

   wire [FIELD_W-1:0] next_data_field =
      int_ack ? '0 :
      cmd_cdf ? n_dig :
      cmd_rmf ? save_field[FIELD_W-1:0] :
      cmd_rtf ? acc_in[FIELD_W-1:0] : data_field;

   wire [FIELD_W-1:0] next_buffer =
      int_ack ? '0 :
      cmd_cif ? n_dig :
      cmd_rmf ? save_field[2*FIELD_W-1:FIELD_W] :
      cmd_rtf ? acc_in[2*FIELD_W-1:FIELD_W] : instruction_field_buffer;

   wire [FIELD_W-1:0] next_instr_field =
      int_ack ? '0 : do_xfer ? instruction_field_buffer : instr_field;

   wire [2*FIELD_W-1:0] next_save_field =
      int_ack ? {instruction_field_buffer, data_field} : save_field;

   wire next_inhibit =
      (cmd_cif || cmd_rmf || cmd_rtf) ? 1'b1 :
      do_xfer ? 1'b0 : inhibit;

   assign int_inhibit = inhibit ||
                        (instruction_field_buffer != instr_field);

   // only this path reads code field
   // field reads OR into bits 3 to 5; save field reads into bits 0 to 5
   wire [ACC_W-1:0] rd_or =
      cmd_rdf ? or_mid(data_field) :
      cmd_rif ? or_mid(instr_field) :
      (cmd_rsf || cmd_gtf) ?
         {{(ACC_W-2*FIELD_W){1'b0}}, save_field} : '0;

   // ****************************************************************
   // field registers
   // ****************************************************************
   // all field state moves together so decode stays one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_field              <= '0;
         instruction_field_buffer <= '0;
         data_field               <= '0;
         save_field               <= '0;
         inhibit                  <= 1'b0;
      end else begin
         instr_field              <= next_instr_field;
         instruction_field_buffer <= next_buffer;
         data_field               <= next_data_field;
         save_field               <= next_save_field;
         inhibit                  <= next_inhibit;
      end
   end

   // working register answer, one cycle after the command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_out  <= '0;
         acc_load <= 1'b0;
      end else begin
         acc_out  <= cmd_rd ? (acc_in | rd_or) : acc_out;
         acc_load <= cmd_rd;
      end
   end

   // ****************************************************************
   // extended address
   // ****************************************************************
   // field chosen per cycle
   mfx_ext_addr #(
      .FIELD_W (FIELD_W)
   ) u_ext (
      .pclk        (pclk),
      .presetn     (presetn),
      .cyc_start   (cyc_start),
      .cyc_phase   (cyc_phase),
      .cyc_mri     (cyc_mri),
      .map_en      (map_en),
      .instr_field (instr_field),
      .data_field  (data_field),
      .ext_addr    (ext_addr),
      .after_defer (after_defer)
   );

   // ****************************************************************
   // apb slave
   // ****************************************************************
   // zero wait states; read data latched in the setup cycle
   wire setup  = psel && !penable;
   wire access = psel && penable;
   wire hit_c  = paddr == mfx_pkg::CTRL_OFF;
   wire hit_s  = paddr == mfx_pkg::STAT_OFF;
   wire [31:0] stat_word =
      (32'(instr_field) << mfx_pkg::ST_IF_LSB) |
      (32'(data_field) << mfx_pkg::ST_DF_LSB) |
      (32'(instruction_field_buffer) << mfx_pkg::ST_IB_LSB) |
      (32'(save_field) << mfx_pkg::ST_SF_LSB) |
      (32'(inhibit) << mfx_pkg::ST_INH) |
      (32'(int_inhibit) << mfx_pkg::ST_BLOCK);
   wire [31:0] next_prdata =
      hit_c ? ctrl : hit_s ? stat_word : 32'h0000_0000;

   assign pready  = 1'b1;
   // unmapped addresses answer with an error
   assign pslverr = access && !(hit_c || hit_s);

   // control written only at the access edge; status is read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= mfx_pkg::CTRL_RST;
         prdata <= '0;
      end else begin
         if (access && pwrite && hit_c)
            ctrl <= pwdata & mfx_pkg::CTRL_RST;
         if (setup)
            prdata <= next_prdata;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fetch;
      cyc_start && cyc_phase == mfx_pkg::MFX_PH_FETCH && map_en;
   endsequence
   sequence s_defer;
      cyc_start && cyc_phase == mfx_pkg::MFX_PH_DEFER && map_en;
   endsequence
   sequence s_exec_df;
      cyc_start && cyc_phase == mfx_pkg::MFX_PH_EXEC && cyc_mri &&
      after_defer && map_en;
   endsequence
   sequence s_intr_then_cycle;
      int_ack ##1 (!iot_stb && !jump_exec && !int_ack) ##1 cyc_start;
   endsequence
   sequence s_quiet_jump;
      jump_exec && !iot_stb && !int_ack;
   endsequence

   fetch_field_a: assert property (
      s_fetch |=> ext_addr == $past(instr_field))
      else $error("fetch not in code field");

   pointer_field_a: assert property (
      s_defer |=> ext_addr == $past(instr_field))
      else $error("pointer not in code field");

   exec_data_a: assert property (
      s_exec_df |=> ext_addr == $past(data_field))
      else $error("indirect operand not in data field");

   cif_buffer_a: assert property (
      cmd_cif && !int_ack |=>
         instruction_field_buffer == $past(n_dig) &&
         $stable(instr_field))
      else $error("change code field touched code field");

   jump_keeps_df_a: assert property (
      s_quiet_jump |=> $stable(data_field))
      else $error("jump changed data field");

   cif_blocks_int_a: assert property (
      cmd_cif && !int_ack ##1 !do_xfer |-> int_inhibit)
      else $error("interrupt open after change code field");

   intr_entry_a: assert property (
      int_ack |=> instr_field == '0 && data_field == '0 &&
         save_field == $past({instruction_field_buffer, data_field}))
      else $error("interrupt entry fields wrong");

   intr_zero_a: assert property (
      s_intr_then_cycle |=> ext_addr == '0)
      else $error("service cycle not in field zero");

   mismatch_inh_a: assert property (
      instruction_field_buffer != instr_field |-> inhibit && int_inhibit)
      else $error("interrupt open with fields unequal");

   panel_jump_a: assert property (
      (s_quiet_jump and panel_mode) |=> $stable(instr_field))
      else $error("panel jump moved code field");

   field_hold_a: assert property (
      !do_xfer && !int_ack |=> $stable(instr_field))
      else $error("code field moved without transfer");

   lif_panel_a: assert property (
      cmd_lif && panel_mode && !int_ack |=>
         instr_field == $past(instruction_field_buffer))
      else $error("panel load code field failed");

   lif_copy_a: assert property (
      cmd_lif && !int_ack |=>
         instr_field == $past(instruction_field_buffer) && !inhibit)
      else $error("load code field failed");

   rdf_or_a: assert property (
      cmd_rdf |=> acc_load &&
         acc_out == ($past(acc_in) | or_mid($past(data_field))))
      else $error("read data field result wrong");

   rif_code_a: assert property (
      cmd_rif |=> acc_load &&
         acc_out == ($past(acc_in) | or_mid($past(instr_field))))
      else $error("read code field result wrong");

   save_read_a: assert property (
      cmd_rsf || cmd_gtf |=> acc_load && acc_out ==
         ($past(acc_in) | {{(ACC_W-2*FIELD_W){1'b0}}, $past(save_field)}))
      else $error("save field read wrong");

   nomap_zero_a: assert property (
      cyc_start && !map_en |=> ext_addr == '0)
      else $error("extended address without mapping");

   rmf_split_a: assert property (
      cmd_rmf && !int_ack |=>
         instruction_field_buffer == $past(save_field[5:3]) &&
         data_field == $past(save_field[2:0]) && inhibit)
      else $error("restore split wrong");

   cdf_digit_a: assert property (
      cmd_cdf && !int_ack |=> data_field == $past(n_dig))
      else $error("change data field wrong");

endmodule // mfx_field_ext

// [rtl/mfx_pkg.sv]
// constants and types shared by the memory field extension block
package mfx_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int FW = 3;                 // one memory field number
   localparam int SW = 6;                 // save field width
   localparam int AW = 12;                // working register width

   // ****************************************************************
   // processor memory cycle phases, one-hot
   // ****************************************************************
   typedef enum logic [2:0] {
      MFX_PH_FETCH = 3'b001,
      MFX_PH_DEFER = 3'b010,
      MFX_PH_EXEC  = 3'b100
   } mfx_phase_e;

   // ****************************************************************
   // i/o instruction codes (octal digits in the comments)
   // ****************************************************************
   localparam logic [5:0]  IOT_GRP  = 6'h32;      // 62xx
   localparam logic [2:0]  SUB_CDF  = 3'h1;       // 62n1
   localparam logic [2:0]  SUB_CIF  = 3'h2;       // 62n2
   localparam logic [2:0]  SUB_CDIF = 3'h3;       // 62n3
   localparam logic [2:0]  SUB_MISC = 3'h4;       // 62n4
   localparam logic [2:0]  N_RDF    = 3'h1;       // 6214
   localparam logic [2:0]  N_RIF    = 3'h2;       // 6224
   localparam logic [2:0]  N_RSF    = 3'h3;       // 6234
   localparam logic [2:0]  N_RMF    = 3'h4;       // 6244
   localparam logic [2:0]  N_LIF    = 3'h5;       // 6254
   localparam logic [11:0] GTF_CODE = 12'hc04;    // 6004
   localparam logic [11:0] RTF_CODE = 12'hc05;    // 6005

   // ****************************************************************
   // register map and fields
   // ****************************************************************
   localparam logic [11:0] CTRL_OFF  = 12'h000;
   localparam logic [11:0] STAT_OFF  = 12'h004;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam int          CTRL_MAP  = 0;         // map enable bit
   localparam int          ST_IF_LSB = 0;
   localparam int          ST_DF_LSB = 3;
   localparam int          ST_IB_LSB = 6;
   localparam int          ST_SF_LSB = 9;
   localparam int          ST_INH    = 15;        // inhibit flip-flop
   localparam int          ST_BLOCK  = 16;        // interrupt blocked

endpackage

// [verification/mfx_cpu_model.sv]
// processor-side model driving memory cycles, i/o, jumps and interrupts
`timescale 1ns/1ns
module mfx_cpu_model (
   input  wire logic        pclk,       // system clock
   output logic             cyc_start,  // memory cycle begins
   output logic [2:0]       cyc_phase,  // one-hot phase
   output logic             cyc_mri,    // and/tad/isz/dca
   output logic             iot_stb,    // i/o instruction pulse
   output logic [11:0]      iot_code,   // instruction word
   output logic [11:0]      acc_in,     // working register
   output logic             jump_exec,  // jump executes
   output logic             panel_mode, // panel memory running
   output logic             int_ack     // interrupt entered
);
   // idle levels; qualifiers turn to the inverse once released so a
   // block that samples them outside a strobe sees garbage, not old data
   initial begin
      cyc_start  = 1'b0;
      cyc_phase  = 3'h0;
      cyc_mri    = 1'b0;
      iot_stb    = 1'b0;
      iot_code   = 12'h000;
      acc_in     = 12'h000;
      jump_exec  = 1'b0;
      panel_mode = 1'b0;
      int_ack    = 1'b0;
   end

   // one memory cycle start, phase and instruction class with it
   task automatic mem_cycle(input logic [2:0] ph, input logic mri);
      @(posedge pclk);
      cyc_start <= 1'b1;
      cyc_phase <= ph;
      cyc_mri   <= mri;
      @(posedge pclk);
      cyc_start <= 1'b0;
      cyc_phase <= ~ph;
      cyc_mri   <= ~mri;
   endtask

   // one i/o instruction with the working register beside it
   task automatic iot(input logic [11:0] code, input logic [11:0] acc);
      @(posedge pclk);
      iot_stb  <= 1'b1;
      iot_code <= code;
      acc_in   <= acc;
      @(posedge pclk);
      iot_stb  <= 1'b0;
      iot_code <= ~code;
      acc_in   <= ~acc;
   endtask

   // one jump (intr=0) or interrupt entry (intr=1) pulse
   task automatic pulse(input logic intr);
      @(posedge pclk);
      int_ack   <= intr;
      jump_exec <= !intr;
      @(posedge pclk);
      int_ack   <= 1'b0;
      jump_exec <= 1'b0;
   endtask

   // panel memory mode changes only between instructions
   task automatic set_panel(input logic v);
      @(posedge pclk);
      panel_mode <= v;
   endtask
endmodule // mfx_cpu_model

// [verification/tb.sv]
// self-checking testbench for the memory field extension block
`timescale 1ns/1ns
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, acc_in, acc_out, iot_code;
   logic [31:0] pwdata, prdata, rd;
   logic        cyc_start, cyc_mri, iot_stb, acc_load, jump_exec;
   logic        panel_mode, int_ack, int_inhibit, err;
   logic [2:0]  cyc_phase, ext_addr;
   int          bad_count, cmp_count, cycles;
   localparam logic [2:0] F = 3'b001, D = 3'b010, E = 3'b100;

   mfx_field_ext dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cyc_start(cyc_start), .cyc_phase(cyc_phase), .cyc_mri(cyc_mri),
      .iot_stb(iot_stb), .iot_code(iot_code), .acc_in(acc_in),
      .acc_out(acc_out), .acc_load(acc_load), .jump_exec(jump_exec),
      .panel_mode(panel_mode), .int_ack(int_ack),
      .int_inhibit(int_inhibit), .ext_addr(ext_addr));
   mfx_cpu_model cpu (.pclk(pclk), .cyc_start(cyc_start),
      .cyc_phase(cyc_phase), .cyc_mri(cyc_mri), .iot_stb(iot_stb),
      .iot_code(iot_code), .acc_in(acc_in), .jump_exec(jump_exec),
      .panel_mode(panel_mode), .int_ack(int_ack));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask

   function automatic logic [11:0] io(input logic [2:0] n,
                                      input logic [2:0] s);
      return {mfx_pkg::IOT_GRP, n, s};
   endfunction

   // status word: blocked, inhibit ff, save, buffer, data, code field
   task automatic stat(input logic [31:0] exp, input logic [31:0] mask);
      apb(1'b0, mfx_pkg::STAT_OFF, 32'h0);
      chk({31'h0, err}, 32'h0, "status error");
      chk(rd & mask, exp, "status");
   endtask

   task automatic cyc(input logic [2:0] ph, input logic mri,
                      input logic [2:0] exp);
      cpu.mem_cycle(ph, mri);
      #1;
      chk({29'h0, ext_addr}, {29'h0, exp}, "ext_addr");
   endtask

   // read command: answer pulse one cycle after the strobe edge
   task automatic rdio(input logic [11:0] c, input logic [11:0] a,
                       input logic [11:0] exp);
      cpu.iot(c, a);
      #1;
      chk({31'h0, acc_load}, 32'h1, "acc_load");
      chk({20'h0, acc_out}, {20'h0, exp}, "acc_out");
   endtask

   task automatic inh(input logic exp);
      #1;
      chk({31'h0, int_inhibit}, {31'h0, exp}, "int_inhibit");
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      apb(1'b0, mfx_pkg::CTRL_OFF, 32'h0);
      chk(rd, mfx_pkg::CTRL_RST, "ctrl reset");
      stat(32'h0, 32'hffff_ffff);
      inh(1'b0);
      apb(1'b1, mfx_pkg::STAT_OFF, 32'hffff_ffff);
      stat(32'h0, 32'hffff_ffff);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      $display("test reset done");
   endtask

   task automatic t_fields;
      cpu.iot(io(3'h2, mfx_pkg::SUB_CDIF), 12'h0);
      stat(32'h1_8090, 32'hffff_ffff);
      cpu.pulse(1'b0);
      stat(32'h0_0092, 32'hffff_ffff);
      cpu.iot(io(3'h5, mfx_pkg::SUB_CDF), 12'h0);
      inh(1'b0);
      cpu.iot(io(3'h3, mfx_pkg::SUB_CIF), 12'h0);
      inh(1'b1);
      cyc(F, 1'b1, 3'h2);
      cyc(E, 1'b1, 3'h2);
      cyc(D, 1'b1, 3'h2);
      cyc(E, 1'b1, 3'h5);
      cyc(D, 1'b1, 3'h2);
      cyc(E, 1'b0, 3'h2);
      cpu.pulse(1'b0);
      inh(1'b0);
      for (int i = 0; i < 3; i++) begin
         cyc(F, 1'b0, 3'h3);
      end
      stat(32'h0_00eb, 32'hffff_ffff);
      rdio(io(mfx_pkg::N_RDF, mfx_pkg::SUB_MISC), 12'h807, 12'h82f);
      rdio(io(mfx_pkg::N_RIF, mfx_pkg::SUB_MISC), 12'h000, 12'h018);
      $display("test fields done");
   endtask

   task automatic t_intr;
      cpu.set_panel(1'b1);
      cpu.iot(io(3'h6, mfx_pkg::SUB_CIF), 12'h0);
      cpu.pulse(1'b0);
      cyc(F, 1'b0, 3'h3);
      inh(1'b1);
      cpu.pulse(1'b1);
      cyc(E, 1'b0, 3'h0);
      cyc(F, 1'b0, 3'h0);
      stat(32'h0000_6a00, 32'h0000_7fff);
      rdio(io(mfx_pkg::N_RSF, mfx_pkg::SUB_MISC), 12'hf00, 12'hf35);
      rdio(mfx_pkg::GTF_CODE, 12'h000, 12'h035);
      rdio(io(mfx_pkg::N_RIF, mfx_pkg::SUB_MISC), 12'h000, 12'h000);
      cpu.iot(io(mfx_pkg::N_RMF, mfx_pkg::SUB_MISC), 12'h0);
      stat(32'h0000_6ba8, 32'h0000_7fff);
      inh(1'b1);
      cpu.iot(io(mfx_pkg::N_LIF, mfx_pkg::SUB_MISC), 12'h0);
      stat(32'h0000_6bae, 32'hffff_ffff);
      cyc(F, 1'b0, 3'h6);
      cpu.set_panel(1'b0);
      $display("test interrupt done");
   endtask

   task automatic t_misc;
      cpu.iot(mfx_pkg::RTF_CODE, 12'h00a);
      inh(1'b1);
      cpu.pulse(1'b0);
      cyc(F, 1'b0, 3'h1);
      cpu.iot(io(3'h0, 3'h7), 12'h0);
      #1;
      chk({31'h0, acc_load}, 32'h0, "undecoded answer");
      stat(32'h0000_6a51, 32'h0000_ffff);
      apb(1'b1, mfx_pkg::CTRL_OFF, 32'h0);
      cyc(F, 1'b0, 3'h0);
      apb(1'b1, mfx_pkg::CTRL_OFF, 32'hffff_ffff);
      apb(1'b0, mfx_pkg::CTRL_OFF, 32'h0);
      chk(rd, 32'h1, "ctrl bit0 only");
      cyc(F, 1'b0, 3'h1);
      $display("test misc done");
   endtask

   // ****************************************************************
   // run control
   // ****************************************************************
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         summarize();
      end
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fields();
      t_intr();
      t_misc();
      summarize();
   end
endmodule // tb
